//--- rtl/asr_regs.sv
// Identification, status and mode registers of the eight-channel converter.
// Assumes every input comes from logic on clk_sys: accesses arrive as one-cycle
// requests from the serial framer and converter events as one-cycle pulses.
`timescale 1ns/10ps

module asr_regs #(
    parameter logic [3:0] ID_UPPER = 4'h5,  // Arbitrary value.
    parameter logic [7:0] REVISION = 8'h00  // Arbitrary value.
) (
    input  wire logic                              clk_sys,
    input  wire logic                              rst,
    input  wire asr_pkg::asr_acc_t                 acc,
    output      logic                              acc_ack,
    output      logic [asr_pkg::DATA_W-1:0]        acc_rdata,
    input  wire logic                              lock_state,
    input  wire logic                              resync_evt,
    input  wire logic                              regmap_crc_changed,
    input  wire logic                              rx_crc_err_evt,
    input  wire logic [asr_pkg::NUM_CH-1:0]        drdy_set,
    input  wire logic [asr_pkg::NUM_CH-1:0]        drdy_clr,
    output      asr_pkg::asr_mode_t                mode_cfg,
    output      logic [asr_pkg::NUM_CH-1:0]        channel_new_data
);

    logic                         lock_flag;
    logic                         resync_occurred_flag;
    logic                         regmap_flag;
    logic                         crc_err_flag;
    logic [asr_pkg::DATA_W-1:0]   status_word;
    logic [asr_pkg::DATA_W-1:0]   mode_word;
    logic [asr_pkg::DATA_W-1:0]   id_word;
    logic [asr_pkg::DATA_W-1:0]   next_rdata;
    logic                         rd_status;
    logic                         wr_mode;
    logic [asr_pkg::NUM_CH-1:0]   drdy_drop;

    assign rd_status = acc.req && !acc.wr && (acc.addr == asr_pkg::ADDR_STATUS);
    assign wr_mode   = acc.req && acc.wr && (acc.addr == asr_pkg::ADDR_MODE);

    // Channels consumed this cycle without fresh data; only the checks below read it.
    assign drdy_drop = drdy_clr & ~drdy_set;

    // The low byte is a revision stamp and may differ between builds.
    assign id_word = {ID_UPPER, asr_pkg::CHAN_COUNT, REVISION};

    // Polynomial, word length and reset flag are shared with the mode register, so
    // status always reports the setting actually in force.
    assign status_word = {lock_flag, resync_occurred_flag, regmap_flag, crc_err_flag,
                          mode_cfg.crc_type,
                          mode_cfg.reset_flag,
                          mode_cfg.word_length_field,
                          channel_new_data};

    // Reserved mode bits are not stored and read as zero.
    assign mode_word = {2'b00, mode_cfg.reg_crc_en, mode_cfg.rx_crc_en, mode_cfg.crc_type,
                        mode_cfg.reset_flag, mode_cfg.word_length_field, 3'b000,
                        mode_cfg.timeout_en, mode_cfg.drdy_sel, mode_cfg.drdy_hiz,
                        mode_cfg.drdy_fmt};

    // Lock is a level from the framer, registered so the status view is glitch free.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lock_flag <= 1'b0;
        end else begin
            lock_flag <= lock_state;
        end
    end

    // Sticky event flags clear when status is read; an event in the same cycle wins.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            resync_occurred_flag <= asr_pkg::STATUS_RST[asr_pkg::ST_RESYNC];
        end else if (resync_evt) begin
            resync_occurred_flag <= 1'b1;
        end else if (rd_status) begin
            resync_occurred_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            regmap_flag <= asr_pkg::STATUS_RST[asr_pkg::ST_REGMAP];
        end else if (regmap_crc_changed && mode_cfg.reg_crc_en) begin
            regmap_flag <= 1'b1;
        end else if (rd_status) begin
            regmap_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            crc_err_flag <= asr_pkg::STATUS_RST[asr_pkg::ST_CRC_ERR];
        end else if (rx_crc_err_evt && mode_cfg.rx_crc_en) begin
            crc_err_flag <= 1'b1;
        end else if (rd_status) begin
            crc_err_flag <= 1'b0;
        end
    end

    // New-data flags clear when the framer has shifted a channel's word out.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            channel_new_data <= asr_pkg::STATUS_RST[asr_pkg::NUM_CH-1:0];
        end else begin
            channel_new_data <= (channel_new_data & ~drdy_clr) | drdy_set;
        end
    end

    // Mode register; the reset flag only ever falls through a host write of 0.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode_cfg.reg_crc_en        <= asr_pkg::MODE_RST[asr_pkg::MD_REG_CRC_EN];
            mode_cfg.rx_crc_en         <= asr_pkg::MODE_RST[asr_pkg::MD_RX_CRC_EN];
            mode_cfg.crc_type          <= asr_pkg::MODE_RST[asr_pkg::MD_CRC_TYPE];
            mode_cfg.reset_flag        <= asr_pkg::MODE_RST[asr_pkg::MD_RESET];
            mode_cfg.word_length_field <= asr_pkg::MODE_RST[asr_pkg::MD_WLEN_LO+:2];
            mode_cfg.timeout_en        <= asr_pkg::MODE_RST[asr_pkg::MD_TIMEOUT];
            mode_cfg.drdy_sel          <= asr_pkg::MODE_RST[asr_pkg::MD_DRDY_SEL_LO+:2];
            mode_cfg.drdy_hiz          <= asr_pkg::MODE_RST[asr_pkg::MD_DRDY_HIZ];
            mode_cfg.drdy_fmt          <= asr_pkg::MODE_RST[asr_pkg::MD_DRDY_FMT];
        end else if (wr_mode) begin
            mode_cfg.reg_crc_en        <= acc.wdata[asr_pkg::MD_REG_CRC_EN];
            mode_cfg.rx_crc_en         <= acc.wdata[asr_pkg::MD_RX_CRC_EN];
            mode_cfg.crc_type          <= acc.wdata[asr_pkg::MD_CRC_TYPE];
            mode_cfg.reset_flag        <= mode_cfg.reset_flag & acc.wdata[asr_pkg::MD_RESET];
            mode_cfg.word_length_field <= acc.wdata[asr_pkg::MD_WLEN_LO+:2];
            mode_cfg.timeout_en        <= acc.wdata[asr_pkg::MD_TIMEOUT];
            mode_cfg.drdy_sel          <= acc.wdata[asr_pkg::MD_DRDY_SEL_LO+:2];
            mode_cfg.drdy_hiz          <= acc.wdata[asr_pkg::MD_DRDY_HIZ];
            mode_cfg.drdy_fmt          <= acc.wdata[asr_pkg::MD_DRDY_FMT];
        end
    end

    // Read mux; writes return zero data and unmapped offsets read as zero.
    always_comb begin
        next_rdata = 16'h0000;
        if (acc.req && !acc.wr) begin
            unique case (acc.addr)
                asr_pkg::ADDR_ID:     next_rdata = id_word;
                asr_pkg::ADDR_STATUS: next_rdata = status_word;
                asr_pkg::ADDR_MODE:   next_rdata = mode_word;
                default:              next_rdata = 16'h0000;
            endcase
        end
    end

    // Every access, mapped or not, is acknowledged one cycle later so the framer
    // never stalls; writes to read-only words simply have no effect.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc_ack   <= 1'b0;
            acc_rdata <= 16'h0000;
        end else begin
            acc_ack   <= acc.req;
            acc_rdata <= next_rdata;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_id_read: assert property (
        (acc.req && !acc.wr && acc.addr == asr_pkg::ADDR_ID)
        |=> (acc_ack && acc_rdata[15:8] == {ID_UPPER, asr_pkg::CHAN_COUNT}))
        else $error("identification word read back wrong");

    chk_status_read: assert property (
        rd_status |=> (acc_ack && acc_rdata == $past(status_word)))
        else $error("status read returned wrong value");

    chk_mode_read: assert property (
        (acc.req && !acc.wr && acc.addr == asr_pkg::ADDR_MODE)
        |=> (acc_rdata[15:14] == 2'b00 && acc_rdata[7:5] == 3'b000 &&
             acc_rdata[asr_pkg::MD_TIMEOUT] == $past(mode_cfg.timeout_en)))
        else $error("mode read returned wrong value");

    chk_lock_follow: assert property (
        lock_state |=> status_word[asr_pkg::ST_LOCK])
        else $error("lock bit did not follow interface lock");

    chk_resync_sticky: assert property (
        (resync_occurred_flag && !rd_status) |=> resync_occurred_flag)
        else $error("resync flag lost before a status read");

    chk_regmap_gate: assert property (
        (regmap_crc_changed && !mode_cfg.reg_crc_en && !rd_status)
        |=> $stable(regmap_flag))
        else $error("register map flag set while checking disabled");

    chk_crc_err_set: assert property (
        (rx_crc_err_evt && mode_cfg.rx_crc_en) |=> status_word[asr_pkg::ST_CRC_ERR])
        else $error("input checksum error not flagged");

    chk_crc_type_write: assert property (
        wr_mode |=> status_word[asr_pkg::ST_CRC_TYPE] == $past(acc.wdata[asr_pkg::MD_CRC_TYPE]))
        else $error("checksum type in status does not match mode write");

    chk_reset_clear: assert property (
        (wr_mode && !acc.wdata[asr_pkg::MD_RESET]) |=> !status_word[asr_pkg::ST_RESET] ##1
        (!status_word[asr_pkg::ST_RESET])[*2])
        else $error("reset flag not cleared by write of zero");

    chk_reset_hold: assert property (
        !status_word[asr_pkg::ST_RESET] |=> !status_word[asr_pkg::ST_RESET])
        else $error("reset flag rose without a device reset");

    chk_word_length_field_write: assert property (
        wr_mode |=> status_word[asr_pkg::ST_WLEN_LO+:2] == $past(acc.wdata[asr_pkg::MD_WLEN_LO+:2]))
        else $error("word length in status does not match mode write");

    chk_drdy_set: assert property (
        (|drdy_set) |=> ((channel_new_data & $past(drdy_set)) == $past(drdy_set)))
        else $error("new data flag lost on set");

    chk_ro_write: assert property (
        (acc.req && acc.wr && acc.addr != asr_pkg::ADDR_MODE)
        |=> ($stable(mode_cfg) && acc_rdata == 16'h0000))
        else $error("write to read-only word had an effect");

    // Checks below cover the pulse handshake, the sticky flags and the values seen at the
    // first edge after reset, where the registers must still hold their reset contents.
    chk_status_reset: assert property (
        $fell(rst) |-> (status_word == asr_pkg::STATUS_RST))
        else $error("status word wrong after reset");

    chk_mode_reset: assert property (
        $fell(rst) |-> (mode_word == asr_pkg::MODE_RST && !acc_ack))
        else $error("mode word wrong after reset");

    chk_ack_latency: assert property (
        acc.req |=> acc_ack)
        else $error("access not acknowledged one cycle later");

    chk_ack_idle: assert property (
        !acc.req |=> !acc_ack)
        else $error("acknowledge without an access");

    chk_write_zero: assert property (
        (acc.req && acc.wr) |=> (acc_rdata == 16'h0000))
        else $error("write returned non-zero read data");

    chk_unmapped_read: assert property (
        (acc.req && !acc.wr && acc.addr > asr_pkg::ADDR_MODE) |=> (acc_rdata == 16'h0000))
        else $error("unmapped offset read back non-zero");

    chk_mode_write: assert property (
        wr_mode |=> (mode_cfg.timeout_en == $past(acc.wdata[asr_pkg::MD_TIMEOUT]) &&
                     mode_cfg.drdy_fmt == $past(acc.wdata[asr_pkg::MD_DRDY_FMT])))
        else $error("mode fields do not match mode write");

    chk_lock_release: assert property (
        !lock_state |=> !status_word[asr_pkg::ST_LOCK])
        else $error("lock bit stayed set after unlock");

    chk_resync_set: assert property (
        resync_evt |=> status_word[asr_pkg::ST_RESYNC])
        else $error("resync flag not set");

    chk_resync_clear: assert property (
        (rd_status && !resync_evt) |=> !status_word[asr_pkg::ST_RESYNC])
        else $error("resync flag not cleared by status read");

    chk_regmap_set: assert property (
        (regmap_crc_changed && mode_cfg.reg_crc_en) |=> status_word[asr_pkg::ST_REGMAP])
        else $error("register map change not flagged");

    chk_regmap_sticky: assert property (
        (regmap_flag && !rd_status) |=> regmap_flag)
        else $error("register map flag lost before a status read");

    chk_regmap_clear: assert property (
        (rd_status && !(regmap_crc_changed && mode_cfg.reg_crc_en))
        |=> !status_word[asr_pkg::ST_REGMAP])
        else $error("register map flag not cleared by status read");

    chk_crc_err_gate: assert property (
        (rx_crc_err_evt && !mode_cfg.rx_crc_en && !rd_status)
        |=> $stable(crc_err_flag))
        else $error("input checksum flag set while checking disabled");

    chk_crc_err_sticky: assert property (
        (crc_err_flag && !rd_status) |=> crc_err_flag)
        else $error("input checksum flag lost before a status read");

    chk_crc_type_hold: assert property (
        !wr_mode |=> $stable(mode_cfg.crc_type))
        else $error("checksum type changed without a mode write");

    chk_reset_keep: assert property (
        (wr_mode && acc.wdata[asr_pkg::MD_RESET]) |=> $stable(mode_cfg.reset_flag))
        else $error("writing one changed the reset flag");

    chk_word_length_field_hold: assert property (
        !wr_mode |=> $stable(mode_cfg.word_length_field))
        else $error("word length changed without a mode write");

    chk_drdy_clear: assert property (
        (|drdy_drop) |=> ((channel_new_data & $past(drdy_drop)) == '0))
        else $error("new data flag not cleared when consumed");

    chk_status_low: assert property (
        rd_status |=> (acc_rdata[7:0] == $past(channel_new_data)))
        else $error("status read returned wrong new data flags");

endmodule // asr_regs

//--- rtl/asr_pkg.sv
// Constants, field layouts and carrier types of the converter's identification,
// status and mode register bank.
// Assumes a serial framer on the same clock that decodes host frames into word
// accesses and feeds converter events as single-cycle pulses.
// Functional notes
// - The identification word sits at offset 00h, is read-only, and its low byte is a revision value software must not rely on.
// - The status word sits at offset 01h, is read-only, and reads 0500h after reset.
// - The mode register sits at offset 02h and reads 0510h after reset.
// - Status bit 15 shows 1 while the serial interface is locked and 0 while unlocked, and is 0 after reset.
// - Status bit 14 is set each time the converters resynchronise, and is 0 after reset.
// - Status bit 13 shows 1 when the register map checksum has changed, and is 0 after reset.
// - Status bit 12 shows 1 when a checksum error was found on serial input data, and is 0 after reset.
// - Status bit 11 shows the checksum polynomial in use, 0 for CCITT (default) and 1 for ANSI.
// - Status bit 10 shows 1 after a device reset and 0 once no reset is pending, so it is 1 after reset.
// - Status bits 9:8 show the word length: 00b 16 bits, 01b 24 bits (default), 10b 32 bits padded, 11b 32 bits sign-extended.
// - Status bits 7 to 0 each show new conversion data for channels 7 to 0, and are 0 after reset.
package asr_pkg;

    localparam int         ADDR_W         = 6;
    localparam int         DATA_W         = 16;
    localparam int         NUM_CH         = 8;

    localparam logic [5:0] ADDR_ID        = 6'h00;
    localparam logic [5:0] ADDR_STATUS    = 6'h01;
    localparam logic [5:0] ADDR_MODE      = 6'h02;

    localparam logic [15:0] STATUS_RST    = 16'h0500;
    localparam logic [15:0] MODE_RST      = 16'h0510;
    localparam logic [3:0]  CHAN_COUNT    = 4'h8;

    // Status word bit positions.
    localparam int         ST_LOCK        = 15;
    localparam int         ST_RESYNC      = 14;
    localparam int         ST_REGMAP      = 13;
    localparam int         ST_CRC_ERR     = 12;
    localparam int         ST_CRC_TYPE    = 11;
    localparam int         ST_RESET       = 10;
    localparam int         ST_WLEN_LO     = 8;

    // Mode register bit positions.
    localparam int         MD_REG_CRC_EN  = 13;
    localparam int         MD_RX_CRC_EN   = 12;
    localparam int         MD_CRC_TYPE    = 11;
    localparam int         MD_RESET       = 10;
    localparam int         MD_WLEN_LO     = 8;
    localparam int         MD_TIMEOUT     = 4;
    localparam int         MD_DRDY_SEL_LO = 2;
    localparam int         MD_DRDY_HIZ    = 1;
    localparam int         MD_DRDY_FMT    = 0;

    typedef struct packed {
        logic                 req;
        logic                 wr;
        logic [ADDR_W-1:0]    addr;
        logic [DATA_W-1:0]    wdata;
    } asr_acc_t;

    typedef struct packed {
        logic                 reg_crc_en;
        logic                 rx_crc_en;
        logic                 crc_type;
        logic                 reset_flag;
        logic [1:0]           word_length_field;
        logic                 timeout_en;
        logic [1:0]           drdy_sel;
        logic                 drdy_hiz;
        logic                 drdy_fmt;
    } asr_mode_t;

endpackage

//--- tb/asr_host_model.sv
// Host side of the register bank: issues one word access at a time.
// Assumes the bank answers with a one-cycle acknowledge on the edge after the request.
`timescale 1ns/10ps

module asr_host_model (
    input  wire logic                       clk_sys,
    output      asr_pkg::asr_acc_t          acc,
    input  wire logic                       acc_ack,
    input  wire logic [asr_pkg::DATA_W-1:0] acc_rdata
);
    initial acc = '0;

    // The request is a single-cycle pulse; holding it would be taken as a second access,
    // so the answer is taken at the following edge, where acknowledge is sampled high.
    task automatic xfer(input logic wr, input logic [5:0] addr, input logic [15:0] wdata,
                        output logic [15:0] rdata, output logic ack);
        @(posedge clk_sys);
        #1 acc = '{req: 1'b1, wr: wr, addr: addr, wdata: wdata};
        @(posedge clk_sys);
        #1 acc = '{req: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
        @(posedge clk_sys);
        ack = acc_ack;
        rdata = acc_rdata;
    endtask
endmodule // asr_host_model

//--- tb/asr_regs_bench.sv
// Self-checking bench for the identification, status and mode registers.
// Assumes the host model issues accesses and the bench drives converter events.
`timescale 1ns/10ps

module asr_regs_bench;
    typedef struct packed {
        logic [15:0] mode;
        logic        lock, rsy, rmap, cerr;
        logic [7:0]  drdy;
        logic [15:0] st;
    } asr_row_t;

    logic              clk_sys = 1'b0;
    logic              rst     = 1'b1;
    asr_pkg::asr_acc_t acc;
    logic              acc_ack;
    logic [15:0]       acc_rdata;
    logic              lock_state = 1'b0, resync_evt = 1'b0, regmap_crc_changed = 1'b0, rx_crc_err_evt = 1'b0;
    logic [7:0]        drdy_set = 8'h00, drdy_clr = 8'h00;
    asr_pkg::asr_mode_t mode_cfg;
    logic [7:0]        channel_new_data;
    logic [15:0]       rd;
    int                mismatches = 0, total_checks = 0, cycles = 0;

    // Enables off in row three prove that checksum events are gated by the mode register.
    asr_row_t rows [8] = '{
        '{16'h0510, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 16'h0500},
        '{16'h3510, 1'b1, 1'b1, 1'b1, 1'b1, 8'h81, 16'hF581},
        '{16'h0910, 1'b0, 1'b0, 1'b1, 1'b1, 8'h7E, 16'h097E},
        '{16'h0510, 1'b1, 1'b0, 1'b0, 1'b0, 8'hFF, 16'h81FF},
        '{16'h0010, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 16'h4000},
        '{16'h0210, 1'b0, 1'b0, 1'b0, 1'b0, 8'h01, 16'h0201},
        '{16'h000F, 1'b0, 1'b0, 1'b0, 1'b0, 8'h3C, 16'h003C},
        '{16'h0310, 1'b0, 1'b0, 1'b0, 1'b0, 8'h80, 16'h0380}};

    always #25 clk_sys = ~clk_sys;

    asr_regs i_dut (.clk_sys(clk_sys), .rst(rst), .acc(acc), .acc_ack(acc_ack), .acc_rdata(acc_rdata),
        .lock_state(lock_state), .resync_evt(resync_evt), .regmap_crc_changed(regmap_crc_changed),
        .rx_crc_err_evt(rx_crc_err_evt), .drdy_set(drdy_set), .drdy_clr(drdy_clr),
        .mode_cfg(mode_cfg), .channel_new_data(channel_new_data));

    asr_host_model i_host (.clk_sys(clk_sys), .acc(acc), .acc_ack(acc_ack), .acc_rdata(acc_rdata));

    task automatic end_of_test();
        if (mismatches == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rw(input logic wr, input logic [5:0] addr, input logic [15:0] wdata, output logic [15:0] rdata);
        logic ack;
        i_host.xfer(wr, addr, wdata, rdata, ack);
        cmp16({15'h0, ack}, 16'h0001);
    endtask

    task automatic do_reset();
        rst = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 rst = 1'b0;
    endtask

    task automatic check_reset();
        cmp16({8'h00, channel_new_data}, 16'h0000);
        rw(1'b0, asr_pkg::ADDR_ID, 16'h0000, rd);
        cmp16(rd, 16'h5800);
        rw(1'b0, asr_pkg::ADDR_STATUS, 16'h0000, rd);
        cmp16(rd, 16'h0500);
        rw(1'b0, asr_pkg::ADDR_MODE, 16'h0000, rd);
        cmp16(rd, 16'h0510);
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            end_of_test();
        end
    end

    initial begin
        logic [15:0] mexp;
        do_reset();
        check_reset();
        foreach (rows[i]) begin
            rw(1'b1, asr_pkg::ADDR_MODE, rows[i].mode, rd);
            cmp16(rd, 16'h0000);
            @(posedge clk_sys);
            #1 {lock_state, resync_evt, regmap_crc_changed, rx_crc_err_evt} = {rows[i].lock, rows[i].rsy,
                rows[i].rmap, rows[i].cerr};
            drdy_set = rows[i].drdy;
            drdy_clr = ~rows[i].drdy;
            @(posedge clk_sys);
            #1 {resync_evt, regmap_crc_changed, rx_crc_err_evt, drdy_set, drdy_clr} = '0;
            rw(1'b0, asr_pkg::ADDR_STATUS, 16'h0000, rd);
            cmp16(rd, rows[i].st);
            cmp16({8'h00, channel_new_data}, {8'h00, rows[i].drdy});
            // Event flags are sticky only until a status read.
            rw(1'b0, asr_pkg::ADDR_STATUS, 16'h0000, rd);
            cmp16(rd, rows[i].st & 16'h8FFF);
            mexp = {rows[i].mode[15:11], rows[i].st[10], rows[i].mode[9:0]};
            rw(1'b0, asr_pkg::ADDR_MODE, 16'h0000, rd);
            cmp16(rd, mexp);
            cmp16({5'h00, mode_cfg}, {5'h00, mexp[13:8], mexp[4:0]});
        end
        rw(1'b1, asr_pkg::ADDR_ID, 16'hFFFF, rd);
        rw(1'b1, asr_pkg::ADDR_STATUS, 16'hFFFF, rd);
        rw(1'b0, asr_pkg::ADDR_ID, 16'h0000, rd);
        cmp16(rd, 16'h5800);
        rw(1'b0, asr_pkg::ADDR_STATUS, 16'h0000, rd);
        cmp16(rd, 16'h0380);
        rw(1'b0, 6'h3F, 16'h0000, rd);
        cmp16(rd, 16'h0000);
        // A resync taken at the same edge as a status read must survive the clear, and a
        // channel set and consumed at once stays flagged.
        fork
            rw(1'b0, asr_pkg::ADDR_STATUS, 16'h0000, rd);
            begin
                @(posedge clk_sys);
                #1 resync_evt = 1'b1;
                drdy_set = 8'h01;
                drdy_clr = 8'h81;
                @(posedge clk_sys);
                #1 {resync_evt, drdy_set, drdy_clr} = '0;
            end
        join
        cmp16(rd, 16'h0380);
        rw(1'b0, asr_pkg::ADDR_STATUS, 16'h0000, rd);
        cmp16(rd, 16'h4301);
        rw(1'b0, asr_pkg::ADDR_STATUS, 16'h0000, rd);
        cmp16(rd, 16'h0301);
        // A second reset in mid-run must bring the reset flag back.
        @(posedge clk_sys);
        #1 do_reset();
        check_reset();
        end_of_test();
    end
endmodule // asr_regs_bench
